// >>> bsc_exec.sv
/*
 * execution of the bit-test skips, subroutine call and register clear.
 * assumes the fetch unit holds instr_i stable for a whole instruction
 * cycle and accepts a new one after fetch_next_o; the register file
 * answers rd_data_i combinationally from rd_addr_o during phase 2.
 */
`timescale 1ns/10ps
`default_nettype none

`include "bsc_params.svh"

module bsc_exec
	import bsc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire bsc_pkg::bsc_instr_t instr_i,
	input wire bsc_pkg::bsc_pc_t pc_i,
	input wire bsc_pkg::bsc_byte_t pc_upper_latch_i,
	input wire bsc_pkg::bsc_byte_t rd_data_i,
	output bsc_pkg::bsc_phase_t phase_o,
	output logic rd_en_o,
	output bsc_pkg::bsc_faddr_t rd_addr_o,
	output logic wr_en_o,
	output bsc_pkg::bsc_faddr_t wr_addr_o,
	output bsc_pkg::bsc_byte_t wr_data_o,
	output logic zero_set_o,
	output logic push_en_o,
	output bsc_pkg::bsc_pc_t stack_top_entry_o,
	output logic pc_load_o,
	output bsc_pkg::bsc_pc_t pc_new_o,
	output logic discard_o,
	output logic fetch_next_o
);
	import bsc_pkg::*;

	typedef enum logic [1:0] {
		BSC_ST_EXEC = 2'h1,
		BSC_ST_IDLE = 2'h2
	} bsc_state_t;

	// operation classes held between decode and the end of the cycle
	localparam logic [2:0] BSC_OPC_NONE = 3'h0;
	localparam logic [2:0] BSC_OPC_SKIP_CLR = 3'h1;
	localparam logic [2:0] BSC_OPC_SKIP_SET = 3'h2;
	localparam logic [2:0] BSC_OPC_CALL = 3'h3;
	localparam logic [2:0] BSC_OPC_CLR = 3'h4;

	bsc_phase_t phase;
	bsc_state_t state_q;
	bsc_state_t state_d;
	logic skip_q;
	logic skip_d;
	logic tested_q;
	logic [2:0] op_q;
	bsc_faddr_t faddr_q;
	bsc_pc_t ret_q;
	bsc_pc_t target_q;

	function automatic logic [2:0] decode_op(input bsc_instr_t ins);
		logic [2:0] op;
		op = BSC_OPC_NONE;
		if (ins[13:10] == `BSC_OP_SKIP_CLR) begin
			op = BSC_OPC_SKIP_CLR;
		end else if (ins[13:10] == `BSC_OP_SKIP_SET) begin
			op = BSC_OPC_SKIP_SET;
		end else if (ins[13:11] == `BSC_OP_CALL) begin
			op = BSC_OPC_CALL;
		end else if (ins[13:7] == `BSC_OP_CLR) begin
			op = BSC_OPC_CLR;
		end
		return op;
	endfunction

	bsc_phase_gen u_phase (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.phase_o(phase)
	);

	wire in_exec = (state_q == BSC_ST_EXEC);
	wire is_skip_clr = in_exec && (op_q == BSC_OPC_SKIP_CLR);
	wire is_skip_set = in_exec && (op_q == BSC_OPC_SKIP_SET);
	wire is_call = in_exec && (op_q == BSC_OPC_CALL);
	wire is_clr = in_exec && (op_q == BSC_OPC_CLR);
	wire [2:0] bit_sel = instr_i[`BSC_BIT_LSB+2:`BSC_BIT_LSB];
	wire bit_val = rd_data_i[bit_sel];
	wire q1 = (phase == BSC_Q1);
	wire q2 = (phase == BSC_Q2);
	wire q3 = (phase == BSC_Q3);
	wire q4 = (phase == BSC_Q4);
	wire cycle_end = q4;
	wire decode_now = q1 && in_exec;
	wire nop_decode = q1 && !in_exec;
	wire [2:0] op_dec = decode_op(instr_i);
	wire reads_reg = is_skip_clr || is_skip_set || is_clr;
	wire [`BSC_FW-1:0] field_addr = instr_i[`BSC_FILE_LSB+`BSC_FW-1:`BSC_FILE_LSB];
	wire [`BSC_LIT_W-1:0] call_lit = instr_i[`BSC_LIT_W-1:0];
	wire [`BSC_LATCH_HI-`BSC_LATCH_LO:0] upper_bits =
		pc_upper_latch_i[`BSC_LATCH_HI:`BSC_LATCH_LO];
	wire [`BSC_PCW-1:0] ret_addr = bsc_pc_t'(pc_i + 1'b1);
	wire [`BSC_PCW-1:0] call_target = {upper_bits, call_lit};

	// skip decision taken in phase 3 from the bit read in phase 2
	wire hit_set = is_skip_set && tested_q;
	wire hit_clr = is_skip_clr && !tested_q;
	wire skip_hit = hit_set || hit_clr;
	wire call_target_ok = is_call;
	// a taken skip or a call is followed by one cycle of four idle phases
	wire two_cycle = skip_q || is_call;

	// strobes stand for exactly one phase clock
	assign rd_en_o = q2 && reads_reg;
	assign rd_addr_o = faddr_q;
	assign wr_en_o = q4 && is_clr;
	assign wr_addr_o = faddr_q;
	assign wr_data_o = `BSC_ZERO_BYTE;
	assign zero_set_o = q4 && is_clr;
	assign push_en_o = q4 && is_call;
	assign stack_top_entry_o = ret_q;
	assign pc_load_o = q4 && call_target_ok;
	assign pc_new_o = target_q;
	assign discard_o = q4 && in_exec && skip_q;
	assign fetch_next_o = cycle_end;
	assign phase_o = phase;

	// idle marks the forced no-op cycle after a taken skip or a call
	always_comb begin
		state_d = state_q;
		skip_d = skip_q;
		case (state_q)
			BSC_ST_EXEC: begin
				if (q3) begin
					skip_d = skip_hit;
				end
				if (cycle_end && two_cycle) begin
					state_d = BSC_ST_IDLE;
				end
			end
			BSC_ST_IDLE: begin
				skip_d = 1'b0;
				if (cycle_end) begin
					state_d = BSC_ST_EXEC;
				end
			end
			default: begin
				state_d = BSC_ST_EXEC;
				skip_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= BSC_ST_EXEC;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			skip_q <= 1'b0;
		end else begin
			skip_q <= skip_d;
		end
	end

	// phase 1 decode latches operands; a no-op cycle decodes nothing
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_q <= BSC_OPC_NONE;
		end else if (decode_now) begin
			op_q <= op_dec;
		end else if (nop_decode) begin
			op_q <= BSC_OPC_NONE;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			faddr_q <= '0;
		end else if (decode_now) begin
			faddr_q <= field_addr;
		end
	end

	// phase 2 samples the tested bit from the register file answer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tested_q <= 1'b0;
		end else if (q2) begin
			tested_q <= bit_val;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ret_q <= `BSC_PC_RST;
		end else if (decode_now) begin
			ret_q <= ret_addr;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			target_q <= `BSC_PC_RST;
		end else if (decode_now) begin
			target_q <= call_target;
		end
	end
endmodule

`default_nettype wire

// >>> bsc_params.svh
/*
 * constants for the skip, call and clear execution block:
 * opcode patterns, field positions, widths and reset values.
 * assumes nothing; included by bsc_pkg.sv and bsc_exec.sv.
 */
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

`define BSC_IW 14
`define BSC_PCW 13
`define BSC_FW 7
`define BSC_OP_SKIP_CLR 4'h6
`define BSC_OP_SKIP_SET 4'h7
`define BSC_OP_CALL 3'h4
`define BSC_OP_CLR 7'h03
`define BSC_BIT_LSB 7
`define BSC_FILE_LSB 0
`define BSC_LIT_W 11
`define BSC_LATCH_HI 4
`define BSC_LATCH_LO 3
`define BSC_PC_RST 13'h0000
`define BSC_ZERO_BYTE 8'h00

`endif

// >>> bsc_pkg.sv
/*
 * types shared by the execution block and its phase sequencer.
 * assumes bsc_params.svh is on the include path.
 */
`include "bsc_params.svh"

package bsc_pkg;
	typedef logic [`BSC_PCW-1:0] bsc_pc_t;
	typedef logic [`BSC_IW-1:0] bsc_instr_t;
	typedef logic [`BSC_FW-1:0] bsc_faddr_t;
	typedef logic [7:0] bsc_byte_t;
	typedef enum logic [3:0] {
		BSC_Q1 = 4'h1,
		BSC_Q2 = 4'h2,
		BSC_Q3 = 4'h4,
		BSC_Q4 = 4'h8
	} bsc_phase_t;
endpackage

// >>> bsc_phase_gen.sv
/*
 * four phase sequencer: every clock advances one phase, q1..q4.
 * assumes one core clock; a full instruction cycle is four clocks.
 */
`timescale 1ns/10ps
`default_nettype none

module bsc_phase_gen
	import bsc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	output bsc_pkg::bsc_phase_t phase_o
);
	import bsc_pkg::*;

	bsc_phase_t phase_q;
	bsc_phase_t phase_d;

	always_comb begin
		case (phase_q)
			BSC_Q1: phase_d = BSC_Q2;
			BSC_Q2: phase_d = BSC_Q3;
			BSC_Q3: phase_d = BSC_Q4;
			BSC_Q4: phase_d = BSC_Q1;
			default: phase_d = BSC_Q1;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_q <= BSC_Q1;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign phase_o = phase_q;
endmodule

`default_nettype wire

// >>> bsc_exec_asserts.sv
/*
 * concurrent checks on the ports of the execution block.
 * assumes it is bound into bsc_exec and sees only that module's ports.
 */
`timescale 1ns/10ps
`default_nettype none
module bsc_exec_asserts
	import bsc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire bsc_pkg::bsc_instr_t instr_i,
	input wire bsc_pkg::bsc_pc_t pc_i,
	input wire bsc_pkg::bsc_byte_t pc_upper_latch_i,
	input wire bsc_pkg::bsc_byte_t rd_data_i,
	input wire bsc_pkg::bsc_phase_t phase_o,
	input wire logic rd_en_o,
	input wire bsc_pkg::bsc_faddr_t rd_addr_o,
	input wire logic wr_en_o,
	input wire bsc_pkg::bsc_faddr_t wr_addr_o,
	input wire bsc_pkg::bsc_byte_t wr_data_o,
	input wire logic zero_set_o,
	input wire logic push_en_o,
	input wire bsc_pkg::bsc_pc_t stack_top_entry_o,
	input wire logic pc_load_o,
	input wire bsc_pkg::bsc_pc_t pc_new_o,
	input wire logic discard_o,
	input wire logic fetch_next_o
);
	import bsc_pkg::*;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	phase_ring_a: assert property (phase_o == BSC_Q1 |=> phase_o == BSC_Q2 ##1
		phase_o == BSC_Q3 ##1 phase_o == BSC_Q4) else $error("phase order");
	read_q2_a: assert property (rd_en_o |-> phase_o == BSC_Q2) else $error("read phase");
	cycle_end_a: assert property (fetch_next_o == (phase_o == BSC_Q4))
		else $error("fetch strobe");
	read_addr_a: assert property (rd_en_o |-> rd_addr_o == instr_i[6:0])
		else $error("read address");
	write_addr_a: assert property (wr_en_o |-> wr_addr_o == instr_i[6:0])
		else $error("write address");
	clear_write_a: assert property (wr_en_o |-> zero_set_o && wr_data_o == 8'h00
		&& $past(rd_en_o, 2)) else $error("clear write");
	call_push_a: assert property (push_en_o |-> pc_load_o &&
		stack_top_entry_o == $past(pc_i, 3) + 13'h0001) else $error("push value");
	call_target_a: assert property (pc_load_o |-> pc_new_o ==
		{$past(pc_upper_latch_i[4:3], 3), $past(instr_i[10:0], 3)}) else $error("pc value");
	idle_cycle_a: assert property ((pc_load_o || discard_o) |=>
		(!(rd_en_o || wr_en_o || push_en_o || discard_o))[*4]) else $error("not idle");
	skip_cause_a: assert property (discard_o |-> $past(rd_en_o, 2) &&
		$past(rd_data_i[instr_i[9:7]], 2) == instr_i[10]) else $error("bad skip");
	skip_taken_a: assert property (rd_en_o && instr_i[13:11] == 3'h3 &&
		rd_data_i[instr_i[9:7]] == instr_i[10] |-> ##2 discard_o) else $error("no skip");
endmodule
`default_nettype wire

// >>> bsc_rf_model.sv
/*
 * register file model: each register holds its own address as value.
 * assumes reads are combinational; shows the inverse while not enabled.
 */
`timescale 1ns/10ps
`default_nettype none
module bsc_rf_model (
	input wire logic en_i,
	input wire logic [6:0] addr_i,
	output logic [7:0] data_o
);
	assign data_o = en_i ? {1'b0, addr_i} : ~{1'b0, addr_i};
endmodule
`default_nettype wire

// >>> tb.sv
/*
 * bench for bsc_exec: one task per scenario, judged on the strobes seen.
 * assumes the register file model and the port checker bound below.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import bsc_pkg::*;
	logic clk_i = 0;
	logic rst_n_i = 0;
	bsc_instr_t instr_i = '0;
	bsc_pc_t pc_i = '0;
	bsc_pc_t pc_nx = '0;
	bsc_pc_t stack_top_entry_o;
	bsc_pc_t pc_new_o;
	bsc_byte_t pc_upper_latch_i = '0;
	bsc_byte_t lat_nx = '0;
	bsc_byte_t rd_data_i;
	bsc_byte_t wr_data_o;
	bsc_faddr_t rd_addr_o;
	bsc_faddr_t wr_addr_o;
	bsc_phase_t phase_o;
	logic rd_en_o, wr_en_o, zero_set_o, push_en_o, pc_load_o, discard_o, fetch_next_o;
	logic [5:0] seen;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	bsc_exec dut_u (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.instr_i(instr_i),
		.pc_i(pc_i),
		.pc_upper_latch_i(pc_upper_latch_i),
		.rd_data_i(rd_data_i),
		.phase_o(phase_o),
		.rd_en_o(rd_en_o),
		.rd_addr_o(rd_addr_o),
		.wr_en_o(wr_en_o),
		.wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o),
		.zero_set_o(zero_set_o),
		.push_en_o(push_en_o),
		.stack_top_entry_o(stack_top_entry_o),
		.pc_load_o(pc_load_o),
		.pc_new_o(pc_new_o),
		.discard_o(discard_o),
		.fetch_next_o(fetch_next_o)
	);
	bsc_rf_model rf_u (.en_i(rd_en_o), .addr_i(rd_addr_o), .data_o(rd_data_i));
	initial forever #5 clk_i = ~clk_i;
	task wrap_up;
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 500) begin
			mismatches++;
			wrap_up();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one instruction of n cycles; strobes seen: rd, wr0, zero, push, load, discard
	task run(input bsc_instr_t ins, input int n, input logic [5:0] exp);
		@(posedge clk_i);
		instr_i <= ins;
		pc_i <= pc_nx;
		pc_upper_latch_i <= lat_nx;
		seen = '0;
		repeat (4 * n) begin
			@(negedge clk_i);
			seen |= {rd_en_o, wr_en_o && wr_data_o === 8'h00, zero_set_o, push_en_o,
				pc_load_o, discard_o};
		end
		chk(seen, exp);
	endtask
	task t_skip_set;
		run({4'h7, 3'd0, 7'h55}, 2, 6'b100001);
		run({4'h7, 3'd1, 7'h55}, 1, 6'b100000);
	endtask
	task t_skip_clr;
		run({4'h6, 3'd7, 7'h55}, 2, 6'b100001);
		run({4'h6, 3'd6, 7'h55}, 1, 6'b100000);
	endtask
	task t_call;
		lat_nx = 8'h18;
		pc_nx = 13'h0fff;
		run({3'h4, 11'h7ff}, 2, 6'b000110);
		chk({pc_new_o, stack_top_entry_o}, {13'h1fff, 13'h1000});
		lat_nx = 8'h08;
		pc_nx = 13'h1fff;
		run({3'h4, 11'h000}, 2, 6'b000110);
		chk({pc_new_o, stack_top_entry_o}, {13'h0800, 13'h0000});
	endtask
	task t_clear;
		run({7'h03, 7'h7f}, 1, 6'b111000);
		chk(wr_addr_o, 7'h7f);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		t_skip_set();
		t_skip_clr();
		t_call();
		t_clear();
		wrap_up();
	end
endmodule
bind bsc_exec bsc_exec_asserts chk_u (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.instr_i(instr_i),
	.pc_i(pc_i),
	.pc_upper_latch_i(pc_upper_latch_i),
	.rd_data_i(rd_data_i),
	.phase_o(phase_o),
	.rd_en_o(rd_en_o),
	.rd_addr_o(rd_addr_o),
	.wr_en_o(wr_en_o),
	.wr_addr_o(wr_addr_o),
	.wr_data_o(wr_data_o),
	.zero_set_o(zero_set_o),
	.push_en_o(push_en_o),
	.stack_top_entry_o(stack_top_entry_o),
	.pc_load_o(pc_load_o),
	.pc_new_o(pc_new_o),
	.discard_o(discard_o),
	.fetch_next_o(fetch_next_o)
);
`default_nettype wire
